// [src/dram_train_defines.svh]
// timing counts, field codes and reset values for the training timing block
`ifndef DRAM_TRAIN_DEFINES_SVH
`define DRAM_TRAIN_DEFINES_SVH

// ==========================================================
// clock and printed times, in picoseconds
`define CLK_SYS_PERIOD_PS 5000
`define CA_REF_MULTI_STEP_SETTLE_PS 250000
`define CA_REF_SINGLE_STEP_SETTLE_PS 80000
`define CKE_HIGH_TO_DQ_TRISTATE_PS 1500
`define TERMINATION_LATENCY_PS 20000
`define LEVELING_FEEDBACK_DELAY_PS 20000

// ==========================================================
// cycle counts: longest times round down, least times round up
`define CYC_FLOOR(ps) ((((ps) / `CLK_SYS_PERIOD_PS) < 1) ? 1 : \
	((ps) / `CLK_SYS_PERIOD_PS))
`define CYC_CEIL(ps) (((ps) + `CLK_SYS_PERIOD_PS - 1) / `CLK_SYS_PERIOD_PS)
`define CA_REF_MULTI_CYC `CYC_FLOOR(`CA_REF_MULTI_STEP_SETTLE_PS)
`define CA_REF_SINGLE_CYC `CYC_FLOOR(`CA_REF_SINGLE_STEP_SETTLE_PS)
`define DQ_TRISTATE_CYC `CYC_CEIL(`CKE_HIGH_TO_DQ_TRISTATE_PS)
`define TERMINATION_CYC `CYC_CEIL(`TERMINATION_LATENCY_PS)
`define LEVELING_FEEDBACK_CYC `CYC_FLOOR(`LEVELING_FEEDBACK_DELAY_PS)

// ==========================================================
// mode write selects and reset values
`define MRW_SEL_CA_REF 2'h0
`define MRW_SEL_TRAINING 2'h1
`define MRW_SEL_LEVELING 2'h2
`define CA_REF_CODE_RST 7'h00

`endif

// [src/dram_train_pkg.sv]
// types shared by the training timing block
package dram_train_pkg;

	typedef logic [6:0] ca_ref_code_t;

	// command bus training data-line driver states
	typedef enum logic [1:0] {
		CBT_IDLE,
		CBT_DRIVE,
		CBT_HOLD
	} cbt_state_e;

endpackage

// [src/link_cross_if.sv]
// carrier for state captured on the link clock toward the system clock
`timescale 1ns/1ps
interface link_cross_if;
	logic cke;
	logic training;
	logic leveling;
	logic ck_phase;
	logic ref_toggle;
	dram_train_pkg::ca_ref_code_t ref_code;

	modport link (
		output cke,
		output training,
		output leveling,
		output ck_phase,
		output ref_toggle,
		output ref_code
	);
	modport core (
		input cke,
		input training,
		input leveling,
		input ck_phase,
		input ref_toggle,
		input ref_code
	);
endinterface

// [src/link_capture.sv]
// link-clock capture of clock enable and mode writes
`timescale 1ns/1ps
`include "dram_train_defines.svh"
module link_capture (
	// link clock and reset
	input wire logic ck_link,
	input wire logic link_rstn,
	// pins sampled on the link clock
	input wire logic cke_pin,
	input wire logic mrw_valid,
	input wire logic [1:0] mrw_sel,
	input wire logic [6:0] mrw_data,
	// toward the system clock
	link_cross_if.link lnk
);

	logic cke_q, cke_d;
	logic train_q, train_d;
	logic level_q, level_d;
	logic phase_q, phase_d;
	logic tgl_q, tgl_d;
	dram_train_pkg::ca_ref_code_t code_q, code_d;

	// ==========================================================
	// mode writes; the code word is held until the next write,
	// so the far side may read it once the toggle has crossed
	always_comb begin
		cke_d = cke_pin;
		phase_d = ~phase_q;
		train_d = train_q;
		level_d = level_q;
		tgl_d = tgl_q;
		code_d = code_q;
		if (mrw_valid) begin
			case (mrw_sel)
				`MRW_SEL_CA_REF: begin
					code_d = mrw_data;
					tgl_d = ~tgl_q;
				end
				`MRW_SEL_TRAINING: train_d = mrw_data[0];
				`MRW_SEL_LEVELING: level_d = mrw_data[0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ck_link) begin
		if (!link_rstn) begin
			cke_q <= 1'b0;
			phase_q <= 1'b0;
			train_q <= 1'b0;
			level_q <= 1'b0;
			tgl_q <= 1'b0;
			code_q <= `CA_REF_CODE_RST;
		end else begin
			cke_q <= cke_d;
			phase_q <= phase_d;
			train_q <= train_d;
			level_q <= level_d;
			tgl_q <= tgl_d;
			code_q <= code_d;
		end
	end

	assign lnk.cke = cke_q;
	assign lnk.training = train_q;
	assign lnk.leveling = level_q;
	assign lnk.ck_phase = phase_q;
	assign lnk.ref_toggle = tgl_q;
	assign lnk.ref_code = code_q;

endmodule

// [src/dram_train_timing.sv]
// device-side timing of reference settling, training exit, termination
// and write leveling feedback
`timescale 1ns/1ps
`include "dram_train_defines.svh"
module dram_train_timing #(
	parameter int DQ_W = 8
) (
	// system clock, reset and enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// link clock and its reset
	input wire logic ck_link,
	input wire logic link_rstn,
	// link pins
	input wire logic cke_pin,
	input wire logic mrw_valid,
	input wire logic [1:0] mrw_sel,
	input wire logic [6:0] mrw_data,
	input wire logic dqs_pin,
	// reference voltage setting
	output logic [6:0] ca_ref_level,
	output logic ca_ref_ready,
	// data lines and termination
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe_n,
	output logic odt_on
);

	localparam int CNT_W = 6;
	localparam int REF_MULTI_CYC = `CA_REF_MULTI_CYC;
	localparam int REF_SINGLE_CYC = `CA_REF_SINGLE_CYC;
	localparam int TRI_CYC = `DQ_TRISTATE_CYC;
	localparam int ODT_CYC = `TERMINATION_CYC;
	localparam int WL_CYC = `LEVELING_FEEDBACK_CYC;

	// ==========================================================
	// link-clock capture
	link_cross_if lnk ();

	link_capture u_link (
		.ck_link(ck_link),
		.link_rstn(link_rstn),
		.cke_pin(cke_pin),
		.mrw_valid(mrw_valid),
		.mrw_sel(mrw_sel),
		.mrw_data(mrw_data),
		.lnk(lnk)
	);

	// ==========================================================
	// synchronisers; the first stage feeds only the second
	logic cke_s1, cke_s2, train_s1, train_s2, level_s1, level_s2;
	logic phase_s1, phase_s2, tgl_s1, tgl_s2, tgl_s3;
	logic dqs_s1, dqs_s2, dqs_s3;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			{cke_s1, cke_s2, train_s1, train_s2} <= 4'h0;
			{level_s1, level_s2, phase_s1, phase_s2} <= 4'h0;
			{tgl_s1, tgl_s2, tgl_s3} <= 3'h0;
			{dqs_s1, dqs_s2, dqs_s3} <= 3'h0;
		end else if (ce) begin
			cke_s1 <= lnk.cke;
			cke_s2 <= cke_s1;
			train_s1 <= lnk.training;
			train_s2 <= train_s1;
			level_s1 <= lnk.leveling;
			level_s2 <= level_s1;
			phase_s1 <= lnk.ck_phase;
			phase_s2 <= phase_s1;
			tgl_s1 <= lnk.ref_toggle;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
			dqs_s1 <= dqs_pin;
			dqs_s2 <= dqs_s1;
			dqs_s3 <= dqs_s2;
		end
	end

	logic ref_ev, dqs_rise;
	assign ref_ev = tgl_s2 ^ tgl_s3;
	assign dqs_rise = level_s2 && dqs_s2 && !dqs_s3;

	// ==========================================================
	// reference setting and its settle timer
	logic [6:0] ref_q, ref_d;
	logic [CNT_W-1:0] settle_q, settle_d;
	logic single_step;
	dram_train_pkg::ca_ref_code_t new_code;

	// the code word is read a few system cycles after its toggle;
	// mode writes are spaced far wider than that, so it is stable
	always_comb begin
		new_code = lnk.ref_code;
		single_step = (new_code == ref_q + 7'h01) ||
			(new_code == ref_q - 7'h01);
		ref_d = ref_q;
		settle_d = settle_q;
		if (settle_q != '0)
			settle_d = settle_q - CNT_W'(1);
		if (ref_ev && new_code != ref_q) begin
			ref_d = new_code;
			if (single_step)
				settle_d = CNT_W'(REF_SINGLE_CYC);
			else
				settle_d = CNT_W'(REF_MULTI_CYC);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ref_q <= `CA_REF_CODE_RST;
			settle_q <= '0;
		end else if (ce) begin
			ref_q <= ref_d;
			settle_q <= settle_d;
		end
	end

	assign ca_ref_level = ref_q;
	assign ca_ref_ready = (settle_q == '0);

	// ==========================================================
	// command bus training data-line driver
	dram_train_pkg::cbt_state_e cbt_q, cbt_d;
	logic [CNT_W-1:0] hold_q, hold_d;

	// after clock enable rises the lines stay driven for the
	// minimum hold, then are released
	always_comb begin
		cbt_d = cbt_q;
		hold_d = hold_q;
		case (cbt_q)
			dram_train_pkg::CBT_IDLE: begin
				if (train_s2 && !cke_s2)
					cbt_d = dram_train_pkg::CBT_DRIVE;
			end
			dram_train_pkg::CBT_DRIVE: begin
				if (cke_s2) begin
					cbt_d = dram_train_pkg::CBT_HOLD;
					hold_d = CNT_W'(TRI_CYC);
				end else if (!train_s2) begin
					cbt_d = dram_train_pkg::CBT_IDLE;
				end
			end
			dram_train_pkg::CBT_HOLD: begin
				if (hold_q <= CNT_W'(1))
					cbt_d = dram_train_pkg::CBT_IDLE;
				else
					hold_d = hold_q - CNT_W'(1);
			end
			default: cbt_d = dram_train_pkg::CBT_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cbt_q <= dram_train_pkg::CBT_IDLE;
			hold_q <= '0;
		end else if (ce) begin
			cbt_q <= cbt_d;
			hold_q <= hold_d;
		end
	end

	// ==========================================================
	// termination follows clock enable after the minimum latency
	logic odt_q, odt_d;
	logic [CNT_W-1:0] odt_cnt_q, odt_cnt_d;

	always_comb begin
		odt_d = odt_q;
		odt_cnt_d = '0;
		if (cke_s2 != odt_q) begin
			if (odt_cnt_q == CNT_W'(ODT_CYC - 1))
				odt_d = cke_s2;
			else
				odt_cnt_d = odt_cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			odt_q <= 1'b0;
			odt_cnt_q <= '0;
		end else if (ce) begin
			odt_q <= odt_d;
			odt_cnt_q <= odt_cnt_d;
		end
	end

	assign odt_on = odt_q;

	// ==========================================================
	// data lines: training echo or leveling feedback
	logic [DQ_W-1:0] dq_q, dq_d;

	// a rising strobe edge samples the clock phase; the sync chain plus
	// one register keeps the answer inside the feedback window
	always_comb begin
		dq_d = dq_q;
		if (dqs_rise)
			dq_d = {DQ_W{phase_s2}};
		else if (cbt_q != dram_train_pkg::CBT_IDLE)
			dq_d = DQ_W'(ref_q);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			dq_q <= '0;
		else if (ce)
			dq_q <= dq_d;
	end

	assign dq_out = dq_q;
	// low while driving
	assign dq_oe_n = !(level_s2 || cbt_q != dram_train_pkg::CBT_IDLE);

	// ==========================================================
	// checks
	logic [CNT_W-1:0] busy_len_q;
	logic last_single_q;

	// helper: length of the last not-ready stretch and its kind
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			busy_len_q <= '0;
			last_single_q <= 1'b0;
		end else if (ce) begin
			if (ref_ev && lnk.ref_code != ref_q) begin
				busy_len_q <= '0;
				last_single_q <= single_step;
			end else if (!ca_ref_ready) begin
				busy_len_q <= busy_len_q + CNT_W'(1);
			end
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn || !ce);

	sequence ref_change_s;
		ref_ev && lnk.ref_code != ref_q;
	endsequence

	sequence cke_exit_s;
		cbt_q == dram_train_pkg::CBT_DRIVE && cke_s2;
	endsequence

	a_ref_apply: assert property (
		ref_change_s |=> ca_ref_level == $past(lnk.ref_code) &&
			!ca_ref_ready)
		else $error("reference change not applied");

	a_ref_single_time: assert property (
		$rose(ca_ref_ready) && last_single_q |->
			busy_len_q == CNT_W'(REF_SINGLE_CYC))
		else $error("single step settle length wrong");

	a_ref_multi_time: assert property (
		$rose(ca_ref_ready) && !last_single_q |->
			busy_len_q == CNT_W'(REF_MULTI_CYC))
		else $error("multi step settle length wrong");

	a_dq_exit_hold: assert property (
		cke_exit_s |=> !dq_oe_n ##1 (dq_oe_n || level_s2))
		else $error("data lines not held then released");

	a_odt_min_lat: assert property (
		cke_s2 != odt_q && odt_cnt_q == '0 |=>
			(odt_q == $past(odt_q))[*3])
		else $error("termination changed too early");

	a_wl_feedback: assert property (
		dqs_rise |-> ##[1:WL_CYC] dq_out == {DQ_W{$past(phase_s2)}})
		else $error("leveling feedback late or wrong");

	// between strobe edges the sampled level must stand on the lines
	a_wl_drive: assert property (
		level_s2 && !dqs_rise && cbt_q == dram_train_pkg::CBT_IDLE |=>
			$stable(dq_out))
		else $error("leveling feedback not held between edges");

endmodule

// [tb/ctrl_model.sv]
// controller-side model: link clock, mode writes, clock enable and strobe
`timescale 1ns/1ps
module ctrl_model (
	// link clock and reset
	output logic ck_link,
	output logic link_rstn,
	// command side pins
	output logic cke_pin,
	output logic mrw_valid,
	output logic [1:0] mrw_sel,
	output logic [6:0] mrw_data,
	output logic dqs_pin
);
	time last_mrw;
	time last_cke;

	// ==========================================================
	// clock
	// kept running: a valid clock is owed around select, enable and strobe
	initial begin
		ck_link = 1'b0;
		forever #80 ck_link = ~ck_link;
	end

	// idle levels at time zero, link reset dropped after two edges
	initial begin
		link_rstn = 1'b0;
		cke_pin = 1'b1;
		mrw_valid = 1'b0;
		mrw_sel = 2'h3;
		mrw_data = 7'h00;
		dqs_pin = 1'b0;
		last_mrw = 0;
		last_cke = 0;
		repeat (2) @(posedge ck_link);
		link_rstn <= 1'b1;
	end

	// ==========================================================
	// tasks
	// one mode write, at least ten link cycles after the last one
	task automatic mode_write(input logic [1:0] sel, input logic [6:0] data);
		// also holds off after enable rises, as leaving training demands
		while ($time - last_mrw < 1600 || $time - last_cke < 250)
			@(posedge ck_link);
		mrw_valid <= 1'b1;
		mrw_sel <= sel;
		mrw_data <= data;
		last_mrw = $time;
		@(posedge ck_link);
		mrw_valid <= 1'b0;
		// released lines must not keep the stale word
		mrw_sel <= ~sel;
		mrw_data <= ~data;
	endtask

	// leveling entry, strobe held low for the full wait before any edge
	task automatic level_on();
		mode_write(2'h2, 7'h01);
		repeat (40) @(posedge ck_link);
	endtask

	// clock enable change at a link edge
	task automatic set_cke(input logic v);
		@(posedge ck_link);
		cke_pin <= v;
		if (v)
			last_cke = $time;
	endtask

	// strobe level change at a link edge
	// never within two link cycles of the last command
	task automatic strobe(input logic v);
		while ($time - last_mrw < 320) @(posedge ck_link);
		@(posedge ck_link);
		dqs_pin <= v;
	endtask

	// core row timings in the hot range; the same-bank activate
	// period grows by twice the step of the others
	function automatic int derated_ps(input int base_ps, input int temp_c,
		input logic same_bank);
		int add_ps;
		add_ps = 0;
		if (temp_c >= 85 && temp_c <= 105)
			add_ps = same_bank ? 3750 : 1875;
		return base_ps + add_ps;
	endfunction
endmodule

// [tb/dram_train_timing_test.sv]
// self-checking bench for the training timing block
`timescale 1ns/1ps
`define CHECK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module dram_train_timing_test;
	logic clk_sys, rstn, ce, ck_link, link_rstn, cke_pin, mrw_valid, dqs_pin;
	logic [1:0] mrw_sel;
	logic [6:0] mrw_data, ca_ref_level;
	logic [7:0] dq_out, lvl_a;
	logic ca_ref_ready, dq_oe_n, odt_on;
	int fail_count, total_checks;
	logic link_phase;

	ctrl_model i_ctrl_model (.ck_link(ck_link), .link_rstn(link_rstn),
		.cke_pin(cke_pin), .mrw_valid(mrw_valid), .mrw_sel(mrw_sel),
		.mrw_data(mrw_data), .dqs_pin(dqs_pin));

	dram_train_timing i_dram_train_timing (.clk_sys(clk_sys), .rstn(rstn),
		.ce(ce), .ck_link(ck_link), .link_rstn(link_rstn), .cke_pin(cke_pin),
		.mrw_valid(mrw_valid), .mrw_sel(mrw_sel), .mrw_data(mrw_data),
		.dqs_pin(dqs_pin), .ca_ref_level(ca_ref_level),
		.ca_ref_ready(ca_ref_ready), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.odt_on(odt_on));

	// ==========================================================
	// clock and helpers
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// link clock level as the device samples it at a strobe edge
	always @(posedge ck_link)
		link_phase <= link_rstn ? ~link_phase : 1'b0;

	task automatic summarize();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// bounded wait for the data-line driver to reach a level
	task automatic wait_oe(input logic v);
		repeat (60) begin
			if (dq_oe_n !== v) begin
				@(posedge clk_sys);
				#1;
			end
		end
	endtask

	// ==========================================================
	// scenarios
	// reference write: count busy cycles over a 2 us window
	task automatic ref_step(input logic [6:0] code, input int len);
		int lows;
		lows = 0;
		i_ctrl_model.mode_write(2'h0, code);
		repeat (400) begin
			@(posedge clk_sys);
			#1;
			if (ca_ref_ready === 1'b0) lows++;
		end
		`CHECK(lows, len)
		`CHECK(ca_ref_level, code)
	endtask

	// reference write with the enable dropped mid-settle: the timer
	// freezes, so the busy stretch grows by exactly the frozen span
	task automatic ref_freeze(input logic [6:0] code, input int len);
		int lows;
		lows = 0;
		i_ctrl_model.mode_write(2'h0, code);
		repeat (400) begin
			@(posedge clk_sys);
			if (lows == 4)
				ce <= 1'b0;
			if (lows == 24)
				ce <= 1'b1;
			#1;
			if (ca_ref_ready === 1'b0) lows++;
		end
		`CHECK(lows, len + 20)
		`CHECK(ca_ref_level, code)
	endtask

	// training exit: echo, hold after enable, termination follows enable
	task automatic training_exit();
		i_ctrl_model.mode_write(2'h1, 7'h01);
		`CHECK(odt_on, 1'b1)
		i_ctrl_model.set_cke(1'b0);
		wait_oe(1'b0);
		`CHECK(odt_on, 1'b1)
		@(posedge clk_sys);
		#1 `CHECK(dq_out, 8'h41)
		repeat (50) @(posedge clk_sys);
		#1 `CHECK(odt_on, 1'b0)
		i_ctrl_model.set_cke(1'b1);
		// the synced enable reaches the driver two system edges after
		// the link edge that takes it; the third starts the one hold cycle
		@(posedge ck_link);
		repeat (3) @(posedge clk_sys);
		#1 `CHECK(dq_oe_n, 1'b0)
		wait_oe(1'b1);
		`CHECK(dq_oe_n, 1'b1)
		repeat (50) @(posedge clk_sys);
		#1 `CHECK(odt_on, 1'b1)
		i_ctrl_model.mode_write(2'h1, 7'h00);
	endtask

	// leveling: rising strobe edges an odd number of link cycles apart
	task automatic leveling();
		i_ctrl_model.level_on();
		`CHECK(dq_oe_n, 1'b0)
		i_ctrl_model.strobe(1'b1);
		repeat (4) @(posedge clk_sys);
		#1 lvl_a = dq_out;
		`CHECK(lvl_a, {8{link_phase}})
		i_ctrl_model.strobe(1'b0);
		i_ctrl_model.strobe(1'b0);
		i_ctrl_model.strobe(1'b1);
		repeat (4) @(posedge clk_sys);
		#1 `CHECK(dq_out, ~lvl_a)
		i_ctrl_model.strobe(1'b0);
		i_ctrl_model.mode_write(2'h2, 7'h00);
		wait_oe(1'b1);
		`CHECK(dq_oe_n, 1'b1)
		i_ctrl_model.strobe(1'b1);
		repeat (8) @(posedge clk_sys);
		#1 `CHECK(dq_out, ~lvl_a)
		i_ctrl_model.strobe(1'b0);
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		fail_count = 0;
		total_checks = 0;
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		#1 `CHECK({ca_ref_level, ca_ref_ready, dq_oe_n, odt_on}, 10'h006)
		`CHECK(i_ctrl_model.derated_ps(18000, 95, 1'b0), 19875)
		`CHECK(i_ctrl_model.derated_ps(42000, 85, 1'b1), 45750)
		`CHECK(i_ctrl_model.derated_ps(18000, 106, 1'b0), 18000)
		ref_step(7'h01, 16);
		ref_step(7'h00, 16);
		ref_step(7'h7F, 16);
		ref_step(7'h40, 50);
		ref_step(7'h40, 0);
		ref_freeze(7'h41, 16);
		training_exit();
		leveling();
		summarize();
	end

	// whole run needs about 25 us
	initial begin
		#200000;
		fail_count++;
		summarize();
	end
endmodule
